// [logic/i2cwr_slave.v]
// Two-wire slave that receives register write packets and hands them out
//
// Overview of operation
// RULE1 - address, four command bytes, then data bytes
// RULE2 - START opens, ack after each byte, STOP
// RULE3 - invalid command leaves register untouched
// RULE4 - first data byte is bits 31:24
// RULE5 - master always sends four data bytes
// RULE6 - master ends with STOP or repeated START
// RULE7 - surplus data bytes get not-acknowledge
// RULE8 - command byte 0 bits 2:0, 011b writes
// RULE9 - port select from byte1[3:0] and byte2[7]
// RULE10 - select values 0 to 5 pick ports
// RULE11 - byte2 bits 5:2 are byte enables
// RULE12 - enabled bytes update, disabled bytes kept
// RULE13 - address from byte2[1:0], byte3, zeros
// RULE14 - slave address 1101 plus three straps
// RULE15 - address bit 0 clear means write
// RULE16 - acknowledge address, command, four data bytes
// RULE17 - commit only after all four data bytes
`timescale 1ns/100ps
`include "i2cwr_map.vh"
module i2cwr_slave #(
  parameter NUM_PORTS = `I2CWR_NUM_PORTS
) (
  // Clock and reset
  input  wire                 core_clk_in,
  input  wire                 rst_n_in,
  // Serial clock pin, driven low only to stretch
  input  wire                 scl_in,
  output wire                 scl_out,
  output wire                 scl_oe_out,
  // Serial data pin
  input  wire                 sda_in,
  output wire                 sda_out,
  output wire                 sda_oe_out,
  // Address straps
  input  wire [2:0]           addr_strap_in,
  // Register write request
  output wire                 wr_valid_out,
  input  wire                 wr_ready_in,
  output wire [NUM_PORTS-1:0] wr_port_sel_out,
  output wire [4:0]           wr_port_out,
  output wire [11:0]          wr_addr_out,
  output wire [3:0]           wr_be_out,
  output wire [31:0]          wr_data_out,
  // Status
  output wire                 busy_out,
  output wire                 bad_cmd_out,
  output wire                 extra_byte_out
);

  // Packet phases
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_CMD    = 3'h2;
  localparam [2:0] ST_DATA   = 3'h3;
  localparam [2:0] ST_EXTRA  = 3'h4;
  localparam [2:0] ST_IGNORE = 3'h5;

  localparam BUF_W = NUM_PORTS + 5 + 12 + 4 + 32;

  // Pin synchronisers, third stage keeps the previous settled value
  reg        scl_s1_q;
  reg        scl_s2_q;
  reg        scl_s3_q;
  reg        sda_s1_q;
  reg        sda_s2_q;
  reg        sda_s3_q;
  reg [2:0]  strap_s1_q;
  reg [2:0]  strap_s2_q;
  reg [2:0]  strap_q;
  reg [1:0]  strap_cnt_q;
  reg        strap_done_q;

  // Receiver state
  reg [2:0]  state_q;
  reg [7:0]  shift_q;
  reg [3:0]  bit_cnt_q;
  reg        ack_slot_q;
  reg [1:0]  idx_q;
  reg [7:0]  cmd_mem [0:3];
  reg [7:0]  data_mem [0:3];
  reg        push_q;
  reg [BUF_W-1:0] pkt_q;

  // Pin drivers and status flops
  reg        sda_oe_q;
  reg        sda_val_q;
  reg        scl_oe_q;
  reg        scl_val_q;
  reg        busy_q;
  reg        bad_cmd_q;
  reg        extra_q;

  wire       buf_in_ready;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire [4:0] psel;
  wire [3:0] be;
  wire [11:0] reg_addr;
  wire [31:0] wr_word;
  wire       cmd_ok;
  wire       addr_hit;
  wire [NUM_PORTS-1:0] port_hot;

  // Edges and bus conditions on settled samples only
  assign scl_rise   = scl_s2_q & ~scl_s3_q;
  assign scl_fall   = ~scl_s2_q & scl_s3_q;
  assign start_cond = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q; // RULE2
  assign stop_cond  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q; // RULE2

  // Address byte match: fixed high bits, strap low bits, write direction
  assign addr_hit = strap_done_q &&
                    (shift_q[7:1] == {`I2CWR_DEV_ADDR_HI, strap_q}) && // RULE14
                    (shift_q[0] == `I2CWR_DIR_WRITE);                  // RULE15

  // Command fields
  assign psel = {cmd_mem[1][`I2CWR_PSEL_HI_MSB:`I2CWR_PSEL_HI_LSB],
                 cmd_mem[2][`I2CWR_PSEL_LO_BIT]};                      // RULE9
  assign be   = cmd_mem[2][`I2CWR_BE_MSB:`I2CWR_BE_LSB];               // RULE11
  assign reg_addr = {cmd_mem[2][`I2CWR_AHI_MSB:`I2CWR_AHI_LSB],
                     cmd_mem[3], `I2CWR_ADDR_LOW};                     // RULE13
  assign cmd_ok = (cmd_mem[0][`I2CWR_OP_MSB:`I2CWR_OP_LSB] == `I2CWR_OP_WRITE) && // RULE8
                  (psel < NUM_PORTS);                                  // RULE10

  // Last data byte is still in the shifter when the word is formed
  assign wr_word = {data_mem[0], data_mem[1], data_mem[2], shift_q};  // RULE4

  // One-hot port routing, one decoder per port
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      // Cut the loop index to the select width on purpose
      localparam [31:0] PNUM_W = gi;
      localparam [4:0]  PNUM   = PNUM_W[4:0];
      assign port_hot[gi] = (psel == PNUM); // RULE10
    end
  endgenerate

  // Three-stage synchronisers for the pins, two-stage for the straps
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s1_q   <= 1'b1;
      scl_s2_q   <= 1'b1;
      scl_s3_q   <= 1'b1;
      sda_s1_q   <= 1'b1;
      sda_s2_q   <= 1'b1;
      sda_s3_q   <= 1'b1;
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      scl_s1_q   <= scl_in;
      scl_s2_q   <= scl_s1_q;
      scl_s3_q   <= scl_s2_q;
      sda_s1_q   <= sda_in;
      sda_s2_q   <= sda_s1_q;
      sda_s3_q   <= sda_s2_q;
      strap_s1_q <= addr_strap_in;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Straps are caught once after release, later pin changes are ignored
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q      <= 3'h0;
    end else if (strap_cnt_q != `I2CWR_STRAP_SETTLE) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else if (!strap_done_q) begin
      strap_q      <= strap_s2_q; // RULE14
      strap_done_q <= 1'b1;
    end
  end

  // Byte receiver, acknowledge driver and packet sequencer
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q    <= ST_IDLE;
      shift_q    <= 8'h00;
      bit_cnt_q  <= 4'h0;
      ack_slot_q <= 1'b0;
      idx_q      <= 2'h0;
      sda_oe_q   <= 1'b0;
      scl_oe_q   <= 1'b0;
      push_q     <= 1'b0;
      pkt_q      <= {BUF_W{1'b0}};
      bad_cmd_q  <= 1'b0;
      extra_q    <= 1'b0;
      cmd_mem[0] <= 8'h00;
      cmd_mem[1] <= 8'h00;
      cmd_mem[2] <= 8'h00;
      cmd_mem[3] <= 8'h00;
      data_mem[0] <= 8'h00;
      data_mem[1] <= 8'h00;
      data_mem[2] <= 8'h00;
      data_mem[3] <= 8'h00;
    end else begin
      bad_cmd_q <= 1'b0;
      extra_q   <= 1'b0;
      // Stretch SCL until the buffer takes the word, nothing is dropped
      if (push_q && buf_in_ready) begin
        push_q   <= 1'b0;
        scl_oe_q <= 1'b0;
      end
      if (start_cond) begin
        // Plain or repeated START restarts framing at the address byte
        state_q    <= ST_ADDR; // RULE2
        bit_cnt_q  <= 4'h0;
        ack_slot_q <= 1'b0;
        sda_oe_q   <= 1'b0;
        idx_q      <= 2'h0;
      end else if (stop_cond) begin
        state_q    <= ST_IDLE; // RULE2
        bit_cnt_q  <= 4'h0;
        ack_slot_q <= 1'b0;
        sda_oe_q   <= 1'b0;
      end else if (state_q != ST_IDLE) begin
        if (scl_rise && (bit_cnt_q < `I2CWR_BYTE_BITS)) begin
          // MSB first, sampled on the rising edge
          shift_q   <= {shift_q[6:0], sda_s2_q};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (scl_fall && (bit_cnt_q == `I2CWR_BYTE_BITS) && !ack_slot_q) begin
          // Byte complete: decide the acknowledge slot on the falling edge
          ack_slot_q <= 1'b1;
          case (state_q)
            ST_ADDR: begin
              if (addr_hit) begin
                sda_oe_q <= 1'b1; // RULE16
                state_q  <= ST_CMD; // RULE1
              end else begin
                state_q  <= ST_IGNORE;
              end
            end
            ST_CMD: begin
              sda_oe_q       <= 1'b1; // RULE16
              cmd_mem[idx_q] <= shift_q;
              idx_q          <= idx_q + 2'h1;
              if (idx_q == `I2CWR_LAST_IDX) begin
                state_q <= ST_DATA; // RULE1
              end
            end
            ST_DATA: begin
              sda_oe_q        <= 1'b1; // RULE16
              data_mem[idx_q] <= shift_q;
              idx_q           <= idx_q + 2'h1;
              if (idx_q == `I2CWR_LAST_IDX) begin
                state_q <= ST_EXTRA; // RULE5
                // Commit happens only once the whole word is in hand
                if (cmd_ok) begin
                  push_q   <= 1'b1; // RULE17
                  scl_oe_q <= ~buf_in_ready;
                  pkt_q    <= {port_hot, psel, reg_addr, be, wr_word}; // RULE12
                end else begin
                  bad_cmd_q <= 1'b1; // RULE3
                end
              end
            end
            ST_EXTRA: begin
              // Data beyond the fourth byte is refused and discarded
              sda_oe_q <= 1'b0; // RULE7
              extra_q  <= 1'b1; // RULE7
            end
            default: begin
              sda_oe_q <= 1'b0;
            end
          endcase
        end else if (scl_fall && ack_slot_q) begin
          // Acknowledge clock over: release SDA for the next byte
          ack_slot_q <= 1'b0;
          bit_cnt_q  <= 4'h0;
          sda_oe_q   <= 1'b0;
        end
      end
    end
  end

  // Pin levels and busy flag; lines only ever pull low
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_val_q <= 1'b0;
      scl_val_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      sda_val_q <= 1'b0;
      scl_val_q <= 1'b0;
      busy_q    <= (state_q != ST_IDLE) | push_q;
    end
  end

  // Write word staging toward the register side
  i2cwr_buf #(
    .WIDTH        (BUF_W)
  ) u_buf (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .in_valid_in  (push_q),
    .in_ready_out (buf_in_ready),
    .in_data_in   (pkt_q),
    .out_valid_out(wr_valid_out),
    .out_ready_in (wr_ready_in),
    .out_data_out ({wr_port_sel_out, wr_port_out, wr_addr_out, wr_be_out, wr_data_out})
  );

  assign sda_out        = sda_val_q;
  assign sda_oe_out     = sda_oe_q;
  assign scl_out        = scl_val_q;
  assign scl_oe_out     = scl_oe_q;
  assign busy_out       = busy_q;
  assign bad_cmd_out    = bad_cmd_q;
  assign extra_byte_out = extra_q;

endmodule

// [logic/i2cwr_map.vh]
// Constants for the two-wire register write slave: fields, codes and timing
`ifndef I2CWR_MAP_VH
`define I2CWR_MAP_VH

// Fixed upper bits of the 7-bit slave address, low three come from straps
`define I2CWR_DEV_ADDR_HI   4'hd
// Direction bit value for a write in the address byte
`define I2CWR_DIR_WRITE     1'b0
// Operation code field of command byte 0
`define I2CWR_OP_MSB        2
`define I2CWR_OP_LSB        0
`define I2CWR_OP_WRITE      3'h3
// Port select: upper bits in command byte 1, lowest bit in command byte 2
`define I2CWR_PSEL_HI_MSB   3
`define I2CWR_PSEL_HI_LSB   0
`define I2CWR_PSEL_LO_BIT   7
// Byte enables in command byte 2
`define I2CWR_BE_MSB        5
`define I2CWR_BE_LSB        2
// Register address bits 11:10 in command byte 2
`define I2CWR_AHI_MSB       1
`define I2CWR_AHI_LSB       0
// Forced low register address bits 1:0
`define I2CWR_ADDR_LOW      2'h0
// Number of ports that a port select may name
`define I2CWR_NUM_PORTS     6
// Index of the last byte of a command or data phase
`define I2CWR_LAST_IDX      2'h3
// Bits per byte, the ninth clock is the acknowledge slot
`define I2CWR_BYTE_BITS     4'h8
// Core clock edges to wait before the strap pins are captured
`define I2CWR_STRAP_SETTLE  2'h3
// Core and bench link clock periods in ns
`define I2CWR_CORE_PERIOD_NS 20
`define I2CWR_LINK_PERIOD_NS 160

`endif

// [logic/i2cwr_buf.v]
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/100ps
module i2cwr_buf #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             core_clk_in,
  input  wire             rst_n_in,
  // Filling side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Draining side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg             out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  reg             skid_valid_q;
  reg [WIDTH-1:0] skid_data_q;

  // Ready is the empty skid slot, so it is a flop and never combinational
  assign in_ready_out  = ~skid_valid_q;
  assign out_valid_out = out_valid_q;
  assign out_data_out  = out_data_q;

  // Output stage first, skid entry catches a word while the receiver stalls
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_valid_q  <= 1'b0;
      out_data_q   <= {WIDTH{1'b0}};
      skid_valid_q <= 1'b0;
      skid_data_q  <= {WIDTH{1'b0}};
    end else if (out_ready_in || !out_valid_q) begin
      if (skid_valid_q) begin
        out_data_q   <= skid_data_q;
        out_valid_q  <= 1'b1;
        skid_valid_q <= 1'b0;
      end else begin
        out_data_q  <= in_data_in;
        out_valid_q <= in_valid_in;
      end
    end else if (in_valid_in && !skid_valid_q) begin
      skid_data_q  <= in_data_in;
      skid_valid_q <= 1'b1;
    end
  end

endmodule

// [dv/i2cwr_asserts.sv]
// Port checker for the two-wire register write slave
`timescale 1ns/100ps
module i2cwr_asserts #(
  parameter NUM_PORTS = 6
) (
  // Clock and reset
  input wire                 core_clk_in,
  input wire                 rst_n_in,
  // Pins
  input wire                 scl_in,
  input wire                 scl_out,
  input wire                 scl_oe_out,
  input wire                 sda_in,
  input wire                 sda_out,
  input wire                 sda_oe_out,
  input wire [2:0]           addr_strap_in,
  // Write request
  input wire                 wr_valid_out,
  input wire                 wr_ready_in,
  input wire [NUM_PORTS-1:0] wr_port_sel_out,
  input wire [4:0]           wr_port_out,
  input wire [11:0]          wr_addr_out,
  input wire [3:0]           wr_be_out,
  input wire [31:0]          wr_data_out,
  // Status
  input wire                 busy_out,
  input wire                 bad_cmd_out,
  input wire                 extra_byte_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Open-drain pins may only pull low
  pin_low_only_a: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  // Acknowledge only inside a framed transfer
  ack_in_frame_a: assert property (sda_oe_out |-> busy_out)
    else $error("ack outside transfer");
  // An acknowledge holds for the five cycles after it rises
  ack_stands_a: assert property ($rose(sda_oe_out) |=> sda_oe_out [*5])
    else $error("ack too short");
  // Low address bits are always zero
  addr_low_zero_a: assert property (wr_valid_out |-> wr_addr_out[1:0] == 2'h0)
    else $error("address low bits set");
  // One-hot select matches a valid port number
  port_map_a: assert property (wr_valid_out |-> wr_port_out < NUM_PORTS &&
    wr_port_sel_out == ({{(NUM_PORTS-1){1'b0}}, 1'b1} << wr_port_out))
    else $error("port select mismatch");
  // A stalled word keeps its data, enables, address and port number
  word_holds_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out &&
    $stable({wr_data_out, wr_be_out, wr_addr_out, wr_port_out}))
    else $error("word changed while stalled");
  // Valid leaves only after a take
  drop_after_take_a: assert property ($fell(wr_valid_out) |-> $past(wr_ready_in))
    else $error("word dropped untaken");
  // A refused command pushes no word
  bad_no_push_a: assert property (bad_cmd_out |-> ##1 !$rose(wr_valid_out) [*3])
    else $error("word after bad command");
  // Surplus bytes are not acknowledged
  extra_nak_a: assert property (extra_byte_out |-> !sda_oe_out [*6])
    else $error("surplus byte acked");
  // Stretch only while a word waits
  stretch_full_a: assert property (scl_oe_out |-> wr_valid_out)
    else $error("stretch with no word");
  take_c: cover property (wr_valid_out && wr_ready_in);
  bad_c: cover property (bad_cmd_out);
  extra_c: cover property (extra_byte_out);
  stretch_c: cover property (scl_oe_out);
endmodule

bind i2cwr_slave i2cwr_asserts #(.NUM_PORTS(NUM_PORTS)) i_chk (.*);

// [dv/i2cwr_master.sv]
// Behavioural two-wire bus master on open-drain clock and data
`timescale 1ns/100ps
module i2cwr_master (
  // Wire levels
  input  wire scl_in,
  input  wire sda_in,
  // Pull-low drives
  output reg  scl_low_out,
  output reg  sda_low_out
);
  // Idle bus released, clock stands still between frames
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // START or repeated START; waiting on SCL honours stretching
  task start;
    begin
      sda_low_out = 1'b0;
      #40 scl_low_out = 1'b0;
      wait (scl_in);
      #40 sda_low_out = 1'b1;
      #40 scl_low_out = 1'b1;
      #40;
    end
  endtask
  task stop;
    begin
      sda_low_out = 1'b1;
      #40 scl_low_out = 1'b0;
      wait (scl_in);
      #40 sda_low_out = 1'b0;
      #40;
    end
  endtask
  // One clock: data set while low, sampled mid-high
  task bit_io(input logic b, output logic r);
    begin
      sda_low_out = !b;
      #40 scl_low_out = 1'b0;
      wait (scl_in);
      #40 r = sda_in;
      #40 scl_low_out = 1'b1;
      #40;
    end
  endtask
  // Byte MSB first, then the acknowledge slot
  task send(input logic [7:0] b, output logic n);
    integer i;
    logic   r;
    begin
      for (i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, n);
    end
  endtask
  // Address, four command bytes, data bytes; no STOP means repeated START next
  task xfer(input [7:0] a, input [31:0] c, input [47:0] d, input integer nd,
            input stp, output logic [13:0] nak);
    integer k;
    logic   n;
    begin
      nak = 14'h0;
      #3 start;
      send(a, n);
      nak = {nak[12:0], n};
      for (k = 0; k < 4; k++) begin
        send(c[31-8*k -: 8], n);
        nak = {nak[12:0], n};
      end
      for (k = 0; k < nd; k++) begin
        send(d[47-8*k -: 8], n);
        nak = {nak[12:0], n};
      end
      if (stp) stop;
    end
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the register write slave
`timescale 1ns/100ps
module testbench;
  // Clock, reset and plain inputs
  reg          core_clk_in   = 1'b0;
  reg          rst_n_in      = 1'b0;
  reg  [2:0]   addr_strap_in = 3'h5;
  reg          wr_ready_in   = 1'b1;
  // Wires; pull-ups win unless someone pulls low
  wire         scl_oe, sda_oe, scl_lo, sda_lo, busy, bad, extra, vld;
  wire         scl_w = !(scl_oe | scl_lo);
  wire         sda_w = !(sda_oe | sda_lo);
  wire [5:0]   sel;
  wire [4:0]   port;
  wire [11:0]  addr;
  wire [3:0]   be;
  wire [31:0]  data;
  logic [58:0] q[$];
  logic [13:0] nak;
  logic        stretched = 1'b0;
  logic        seen_busy = 1'b0;
  integer      n_errors = 0, tests_run = 0, n_bad = 0, n_extra = 0, cyc = 0;
  always #10 core_clk_in = !core_clk_in;
  i2cwr_master i_mst (.scl_in(scl_w), .sda_in(sda_w), .scl_low_out(scl_lo),
    .sda_low_out(sda_lo));
  i2cwr_slave i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_w),
    .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
    .addr_strap_in(addr_strap_in), .wr_valid_out(vld), .wr_ready_in(wr_ready_in),
    .wr_port_sel_out(sel), .wr_port_out(port), .wr_addr_out(addr), .wr_be_out(be),
    .wr_data_out(data), .busy_out(busy), .bad_cmd_out(bad), .extra_byte_out(extra));
  // Collect taken words and pulses; a hang counts as a mismatch
  always @(posedge core_clk_in) begin
    if (vld && wr_ready_in) q.push_back({sel, port, addr, be, data});
    if (bad) n_bad++;
    if (extra) n_extra++;
    if (scl_oe) stretched = 1'b1;
    if (busy) seen_busy = 1'b1;
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop;
    end
  end
  function automatic [31:0] cmd(input [2:0] op, input [4:0] p, input [11:0] a,
                                input [3:0] e);
    // Reserved bits set high, they must be ignored
    cmd = {5'h1f, op, 4'hf, p[4:1], p[0], 1'b1, e, a[11:10], a[9:2]};
  endfunction
  function automatic [58:0] word(input [4:0] p, input [11:0] a, input [3:0] e,
                                 input [31:0] d);
    word = {6'h01 << p, p, a[11:2], 2'h0, e, d};
  endfunction
  task chk(input string what, input logic [63:0] e, input logic [63:0] g);
    begin
      tests_run++;
      if (g !== e) begin
        n_errors++;
        $display("BAD %s exp %h got %h", what, e, g);
      end
    end
  endtask
  // Pops one taken word; an empty queue is a mismatch
  task chk_q(input string what, input logic [58:0] e);
    begin
      if (q.size() == 0) chk(what, e, 59'h0);
      else chk(what, e, q.pop_front());
    end
  endtask
  task pk(input [7:0] a, input [2:0] op, input [4:0] p, input [11:0] ad,
          input [3:0] e, input [47:0] d, input integer nd, input stp);
    i_mst.xfer(a, cmd(op, p, ad, e), d, nd, stp, nak);
  endtask
  task t_basic;
    begin
      seen_busy = 1'b0;
      pk(8'hda, 3'h3, 5'h0, 12'h0f8, 4'hf, 48'h1234_5678_0000, 4, 1);
      // Busy must have shown during the frame and dropped once STOP settled
      repeat (4) @(negedge core_clk_in);
      chk("busy seen", 1, seen_busy);
      chk("busy idle", 0, busy);
      chk("basic acks", 0, nak[8:0]);
      chk_q("basic word", word(0, 12'h0f8, 4'hf, 32'h1234_5678));
    end
  endtask
  // Six packets on repeated START; the consumer stalls for the first 60000 ns only
  task t_ports;
    integer p;
    begin
      @(negedge core_clk_in) wr_ready_in = 1'b0;
      stretched = 1'b0;
      fork
        for (p = 0; p < 6; p++) pk(8'hda, 3'h3, p[4:0], {p[1:0], 10'h1c4}, p[3:0],
          {p[7:0] ^ 8'h40, 40'h55aa3c_0000}, 4, p == 5);
        begin
          #60000;
          @(negedge core_clk_in) wr_ready_in = 1'b1;
        end
      join
      for (p = 0; p < 6; p++) chk_q("port word", word(p[4:0], {p[1:0], 10'h1c4},
        p[3:0], {p[7:0] ^ 8'h40, 24'h55aa3c}));
      chk("stretch", 1, stretched);
    end
  endtask
  // Every other opcode, then ports beyond the last
  task t_bad;
    integer op;
    begin
      n_bad = 0;
      for (op = 0; op < 8; op++) if (op != 3) pk(8'hda, op[2:0], 5'h1, 12'h004, 4'hf,
        48'h0, 4, 1);
      pk(8'hda, 3'h3, 5'h6, 12'h004, 4'hf, 48'h0, 4, 1);
      pk(8'hda, 3'h3, 5'h1f, 12'h004, 4'hf, 48'h0, 4, 1);
      chk("bad acks", 0, nak[8:0]);
      chk("bad pulses", 9, n_bad);
      chk("bad words", 0, q.size());
    end
  endtask
  task t_extra;
    begin
      n_extra = 0;
      pk(8'hda, 3'h3, 5'h2, 12'h3fc, 4'h9, 48'h0102_0304_0506, 6, 1);
      chk("extra naks", 11'h3, nak[10:0]);
      chk("extra pulses", 2, n_extra);
      chk_q("extra word", word(2, 12'h3fc, 4'h9, 32'h0102_0304));
    end
  endtask
  // Foreign address, read direction, then a packet cut short
  task t_refuse;
    begin
      pk(8'hd8, 3'h3, 5'h0, 12'h010, 4'hf, 48'h0, 4, 1);
      chk("strap naks", 9'h1ff, nak[8:0]);
      pk(8'hdb, 3'h3, 5'h0, 12'h010, 4'hf, 48'h0, 4, 1);
      chk("read naks", 9'h1ff, nak[8:0]);
      pk(8'hda, 3'h3, 5'h0, 12'h010, 4'hf, 48'hffff_0000_0000, 2, 1);
      chk("cut acks", 0, nak[6:0]);
      chk("refused words", 0, q.size());
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Reset, settle, then the scenarios
  initial begin
    repeat (5) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (12) @(negedge core_clk_in);
    t_basic;
    t_ports;
    t_bad;
    t_extra;
    t_refuse;
    report_and_stop;
  end
endmodule
